// ===== verilog/scl_map.svh
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// timing values in ns, clock at 100 MHz (10 ns period)
`define SCL_CLK_PERIOD_NS  10
`define SCL_T_DAL_NS       30
`define SCL_T_RP_NS        20
`define SCL_T_MCD_NS       20
`define SCL_T_RC_NS        70
`define SCL_T_RCD_NS       20
`define SCL_T_RAS_NS       42
`define SCL_T_RRD_NS       20
// least times round up
`define SCL_CYC(ns) (((ns) + `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)
// address field positions, full-page burst code and mode reset value
`define SCL_BANK_BIT       11
`define SCL_AP_BIT         10
`define SCL_BL_LSB         0
`define SCL_BL_FULL_PAGE   3'h7
`define SCL_MODE_RESET     12'h000
`endif

// ===== verilog/scl_pkg.sv
package scl_pkg;
   typedef enum logic [3:0] {
      SCL_CMD_DESELECT,
      SCL_CMD_NOP,
      SCL_CMD_BURST_STOP,
      SCL_CMD_READ,
      SCL_CMD_WRITE,
      SCL_CMD_ACTIVATE,
      SCL_CMD_PRECHARGE,
      SCL_CMD_REFRESH,
      SCL_CMD_MODE_SET
   } scl_cmd_t;

   typedef enum logic [3:0] {
      SCL_ST_IDLE,
      SCL_ST_ACTIVE,
      SCL_ST_WRITE_AP,
      SCL_ST_REFRESH,
      SCL_ST_MODE_SET,
      SCL_ST_SELF_REFRESH,
      SCL_ST_SELF_RECOVERY,
      SCL_ST_POWER_DOWN
   } scl_state_t;

   // pin levels to command code
   function automatic scl_cmd_t scl_decode(input logic cs_n,
                                           input logic ras_n,
                                           input logic cas_n,
                                           input logic we_n);
      scl_cmd_t c;
      c = SCL_CMD_DESELECT;
      if (!cs_n) begin
         case ({ras_n, cas_n, we_n})
            3'h7: c = SCL_CMD_NOP;
            3'h6: c = SCL_CMD_BURST_STOP;
            3'h5: c = SCL_CMD_READ;
            3'h4: c = SCL_CMD_WRITE;
            3'h3: c = SCL_CMD_ACTIVATE;
            3'h2: c = SCL_CMD_PRECHARGE;
            3'h1: c = SCL_CMD_REFRESH;
            default: c = SCL_CMD_MODE_SET;
         endcase
      end
      return c;
   endfunction : scl_decode
endpackage : scl_pkg

// ===== verilog/scl_link_if.sv
interface scl_link_if;
   logic        cke;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [11:0] addr;

   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr);
   modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, addr);
endinterface : scl_link_if

// ===== verilog/scl_delay_timer.sv
`include "scl_map.svh"
module scl_delay_timer
   import scl_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         i_core_clk,  // clock
   input  wire logic         i_reset_n,   // async reset
   input  wire logic         i_load,      // start a wait
   input  wire logic [W-1:0] i_cycles,    // wait length, at least 1
   input  wire logic         i_hold,      // freeze count
   output logic              o_done       // wait finished, level
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (i_load) begin
         next_count = i_cycles;
      end else if (!i_hold && count != '0) begin
         next_count = count - W'(1);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign o_done = (count == '0) && !i_load;
endmodule : scl_delay_timer

// ===== verilog/scl_device.sv
`include "scl_map.svh"
module scl_device
   import scl_pkg::*;
#(
   parameter int BURST_CYCLES = 4,
   parameter int ROW_BITS     = 12
) (
   input  wire logic        i_core_clk,      // clock
   input  wire logic        i_reset_n,       // async reset
   scl_link_if.dev          link,            // command pins
   output logic [11:0]      o_mode,          // mode register
   output scl_state_t       o_state,         // device state
   output logic [1:0]       o_bank_open,     // bank active flags
   output logic             o_clk_suspended, // internal clock held
   output logic             o_illegal,       // illegal command pulse
   output logic [ROW_BITS-1:0] o_refresh_row // internal refresh row
);
   localparam logic [7:0] DAL_CYC = 8'(`SCL_CYC(`SCL_T_DAL_NS));
   localparam logic [7:0] RP_CYC  = 8'(`SCL_CYC(`SCL_T_RP_NS));
   localparam logic [7:0] MCD_CYC = 8'(`SCL_CYC(`SCL_T_MCD_NS));
   localparam logic [7:0] RC_CYC  = 8'(`SCL_CYC(`SCL_T_RC_NS));
   localparam logic [7:0] BUR_CYC = 8'(BURST_CYCLES);
   // waits load one short: the edge that saw the command is the first
   // cycle, so idle is reached exactly when the interval has elapsed

   // ==========================================================
   // input sampling
   // ==========================================================
   logic cke_prev;
   scl_cmd_t cmd;
   logic bank_sel;
   logic auto_pre;
   logic full_page;

   // all strobes are decoded combinationally here; the state registers take the result at the rising edge
   always_comb begin
      cmd       = scl_decode(link.cs_n, link.ras_n, link.cas_n,
                             link.we_n);
      bank_sel  = link.addr[`SCL_BANK_BIT];
      auto_pre  = link.addr[`SCL_AP_BIT];
      full_page = (o_mode[`SCL_BL_LSB +: 3] == `SCL_BL_FULL_PAGE);
   end

   // ==========================================================
   // state machine
   // ==========================================================
   scl_state_t state, next_state;
   logic [1:0] bank_open, next_bank_open;
   logic [1:0] bank_ap, next_bank_ap;
   logic [11:0] mode, next_mode;
   logic suspended, next_suspended;
   logic illegal, next_illegal;
   logic [ROW_BITS-1:0] ref_row, next_ref_row;
   logic t_load, t_hold, t_done;
   logic [7:0] t_cycles;
   logic burst_stop;

   scl_delay_timer #(.W(8)) u_timer (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_load     (t_load),
      .i_cycles   (t_cycles),
      .i_hold     (t_hold),
      .o_done     (t_done)
   );

   always_comb begin
      next_state     = state;
      next_bank_open = bank_open;
      next_bank_ap   = bank_ap;
      next_mode      = mode;
      next_suspended = suspended;
      next_illegal   = 1'b0;
      next_ref_row   = ref_row;
      t_load         = 1'b0;
      t_cycles       = 8'h00;
      t_hold         = suspended;
      burst_stop     = 1'b0;
      case (state)
         SCL_ST_SELF_REFRESH: begin
            // clock enable is looked at here, and the command only in the cycle that enable is high
            if (link.cke) begin
               next_state = SCL_ST_SELF_RECOVERY;
               t_load     = 1'b1;
               t_cycles   = RC_CYC - 8'h01;
               if (cmd != SCL_CMD_DESELECT && cmd != SCL_CMD_NOP &&
                   cmd != SCL_CMD_BURST_STOP) begin
                  next_illegal = 1'b1;
               end
            end
         end
         SCL_ST_SELF_RECOVERY: begin
            if (cmd != SCL_CMD_DESELECT && cmd != SCL_CMD_NOP &&
                cmd != SCL_CMD_BURST_STOP) begin
               next_illegal = 1'b1;
            end else if (cke_prev && !link.cke) begin
               next_state = SCL_ST_POWER_DOWN;
            end else if (t_done) begin
               next_state = SCL_ST_IDLE;
            end
         end
         SCL_ST_POWER_DOWN: begin
            if (!cke_prev && link.cke) begin
               next_state = SCL_ST_IDLE;
            end
         end
         SCL_ST_IDLE: begin
            if (cke_prev && !link.cke) begin
               if (cmd == SCL_CMD_REFRESH) begin
                  next_state = SCL_ST_SELF_REFRESH;
               end else begin
                  next_state = SCL_ST_POWER_DOWN;
               end
            end else if (!cke_prev) begin
               next_state = SCL_ST_POWER_DOWN;
            end else begin
               case (cmd)
                  SCL_CMD_ACTIVATE: begin
                     next_bank_open[bank_sel] = 1'b1;
                     next_state = SCL_ST_ACTIVE;
                  end
                  SCL_CMD_REFRESH: begin
                     // row from the internal counter
                     next_ref_row = ref_row + ROW_BITS'(1);
                     next_state   = SCL_ST_REFRESH;
                     t_load       = 1'b1;
                     t_cycles     = RP_CYC - 8'h01;
                  end
                  SCL_CMD_MODE_SET: begin
                     next_mode  = link.addr;
                     next_state = SCL_ST_MODE_SET;
                     t_load     = 1'b1;
                     t_cycles   = MCD_CYC - 8'h01;
                  end
                  SCL_CMD_READ, SCL_CMD_WRITE: begin
                     next_illegal = 1'b1;
                  end
                  default: ;
               endcase
            end
         end
         SCL_ST_REFRESH, SCL_ST_MODE_SET: begin
            if (cmd != SCL_CMD_DESELECT && cmd != SCL_CMD_NOP &&
                cmd != SCL_CMD_BURST_STOP) begin
               next_illegal = 1'b1;
            end else if (t_done) begin
               next_state = SCL_ST_IDLE;
            end
         end
         default: begin // active banks and write-AP recovery
            // clock suspend entry and exit
            if (cke_prev && !link.cke) begin
               next_suspended = 1'b1;
            end else if (suspended && link.cke) begin
               next_suspended = 1'b0;
            end
            if (!suspended && cke_prev) begin
               case (cmd)
                  SCL_CMD_ACTIVATE: begin
                     if (bank_open[bank_sel] || bank_ap[bank_sel]) begin
                        next_illegal = 1'b1;
                     end else begin
                        next_bank_open[bank_sel] = 1'b1;
                     end
                  end
                  SCL_CMD_READ, SCL_CMD_WRITE: begin
                     if (!bank_open[bank_sel] || bank_ap[bank_sel]) begin
                        next_illegal = 1'b1;
                     end else if (auto_pre) begin
                        next_bank_ap[bank_sel] = 1'b1;
                        next_state = SCL_ST_WRITE_AP;
                        t_load     = 1'b1;
                        t_cycles   = BUR_CYC + DAL_CYC - 8'h01;
                     end
                  end
                  SCL_CMD_PRECHARGE: begin
                     if (auto_pre) begin
                        next_bank_open = bank_open & bank_ap;
                     end else if (!bank_ap[bank_sel]) begin
                        next_bank_open[bank_sel] = 1'b0;
                     end else begin
                        next_illegal = 1'b1;
                     end
                  end
                  SCL_CMD_BURST_STOP: begin
                     burst_stop = full_page;
                  end
                  SCL_CMD_REFRESH, SCL_CMD_MODE_SET: begin
                     next_illegal = 1'b1;
                  end
                  default: ;
               endcase
            end
            // auto-precharge bank closes once its wait runs out
            if (bank_ap != 2'h0 && t_done && !t_load) begin
               next_bank_open = next_bank_open & ~bank_ap;
               next_bank_ap   = 2'h0;
            end
            if (burst_stop && bank_ap != 2'h0) begin
               // stop cuts the burst: precharge right away
               next_bank_open = next_bank_open & ~bank_ap;
               next_bank_ap   = 2'h0;
            end
            if (next_bank_ap != 2'h0) begin
               next_state = SCL_ST_WRITE_AP;
            end else if (next_bank_open != 2'h0) begin
               next_state = SCL_ST_ACTIVE;
            end else begin
               next_state     = SCL_ST_IDLE;
               next_suspended = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state     <= SCL_ST_IDLE;
         bank_open <= 2'h0;
         bank_ap   <= 2'h0;
         mode      <= `SCL_MODE_RESET;
         suspended <= 1'b0;
         illegal   <= 1'b0;
         ref_row   <= '0;
         cke_prev  <= 1'b1;
      end else begin
         state     <= next_state;
         bank_open <= next_bank_open;
         bank_ap   <= next_bank_ap;
         mode      <= next_mode;
         suspended <= next_suspended;
         illegal   <= next_illegal;
         ref_row   <= next_ref_row;
         cke_prev  <= link.cke;
      end
   end

   assign o_mode          = mode;
   assign o_state         = state;
   assign o_bank_open     = bank_open;
   assign o_clk_suspended = suspended;
   assign o_illegal       = illegal;
   assign o_refresh_row   = ref_row;
endmodule : scl_device

// ===== verilog/scl_controller.sv
`include "scl_map.svh"
module scl_controller
   import scl_pkg::*;
(
   input  wire logic        i_core_clk,  // clock
   input  wire logic        i_reset_n,   // async reset
   input  wire logic        i_req,       // command request
   input  scl_cmd_t         i_cmd,       // requested command
   input  wire logic [11:0] i_addr,      // address, bit 11 bank
   input  wire logic        i_cke,       // clock enable level wanted
   output logic             o_ready,     // request taken this cycle
   scl_link_if.ctrl         link         // command pins
);
   localparam logic [7:0] RCD_CYC = 8'(`SCL_CYC(`SCL_T_RCD_NS));
   localparam logic [7:0] RAS_CYC = 8'(`SCL_CYC(`SCL_T_RAS_NS));
   localparam logic [7:0] RRD_CYC = 8'(`SCL_CYC(`SCL_T_RRD_NS));
   localparam logic [7:0] RP_CYC  = 8'(`SCL_CYC(`SCL_T_RP_NS));
   localparam logic [7:0] MCD_CYC = 8'(`SCL_CYC(`SCL_T_MCD_NS));
   localparam logic [7:0] RC_CYC  = 8'(`SCL_CYC(`SCL_T_RC_NS));
   localparam logic [7:0] DAL_CYC = 8'(`SCL_CYC(`SCL_T_DAL_NS) + 4);

   // ==========================================================
   // bank tracking and wait counters
   // ==========================================================
   logic [1:0] open, next_open;
   logic [1:0] ap, next_ap;
   logic [7:0] busy, next_busy;      // all-bank wait
   logic [7:0] rrd, next_rrd;
   logic [7:0] rcd [2], next_rcd [2];
   logic [7:0] ras [2], next_ras [2];
   logic       bank;
   logic       ok;
   logic [3:0] pins;

   always_comb begin
      bank = i_addr[`SCL_BANK_BIT];
      // nothing is issued while the enable pin is still low
      ok   = (busy == 8'h00) && link.cke;
      case (i_cmd)
         SCL_CMD_ACTIVATE:
            ok = ok && !open[bank] && !ap[bank] && rrd == 8'h00;
         SCL_CMD_READ, SCL_CMD_WRITE:
            ok = ok && open[bank] && !ap[bank]
                 && rcd[bank] == 8'h00;
         SCL_CMD_PRECHARGE:
            ok = ok && !ap[bank] && ras[0] == 8'h00
                 && ras[1] == 8'h00;
         SCL_CMD_REFRESH, SCL_CMD_MODE_SET:
            ok = ok && open == 2'h0 && ap == 2'h0;
         SCL_CMD_BURST_STOP:
            ok = ok && open != 2'h0;
         default: ;
      endcase
      // a refresh taken with enable low is self-refresh entry
      o_ready = i_req && ok && (i_cke || i_cmd == SCL_CMD_REFRESH);
   end

   always_comb begin
      next_open = open;
      next_ap   = ap;
      // the device freezes its waits while its clock is suspended
      next_busy = (busy != 8'h00 && link.cke) ? busy - 8'h01 : busy;
      next_rrd  = (rrd != 8'h00) ? rrd - 8'h01 : rrd;
      for (int b = 0; b < 2; b++) begin
         next_rcd[b] = (rcd[b] != 8'h00) ? rcd[b] - 8'h01 : rcd[b];
         next_ras[b] = (ras[b] != 8'h00) ? ras[b] - 8'h01 : ras[b];
      end
      // leaving power-down or self-refresh: wait out recovery
      if (!link.cke && i_cke && open == 2'h0 && ap == 2'h0) begin
         next_busy = RC_CYC;
      end
      if (ap != 2'h0 && busy == 8'h01) begin
         next_open = open & ~ap;
         next_ap   = 2'h0;
      end
      pins = 4'hF;                                   // deselect
      if (o_ready) begin
         case (i_cmd)
            SCL_CMD_NOP:        pins = 4'h7;
            SCL_CMD_BURST_STOP: pins = 4'h6;
            SCL_CMD_READ:       pins = 4'h5;
            SCL_CMD_WRITE:      pins = 4'h4;
            SCL_CMD_ACTIVATE:   pins = 4'h3;
            SCL_CMD_PRECHARGE:  pins = 4'h2;
            SCL_CMD_REFRESH:    pins = 4'h1;
            SCL_CMD_MODE_SET:   pins = 4'h0;
            default:            pins = 4'hF;
         endcase
         case (i_cmd)
            SCL_CMD_ACTIVATE: begin
               next_open[bank] = 1'b1;
               next_rrd        = RRD_CYC;
               next_rcd[bank]  = RCD_CYC;
               next_ras[bank]  = RAS_CYC;
            end
            SCL_CMD_READ, SCL_CMD_WRITE: begin
               if (i_addr[`SCL_AP_BIT]) begin
                  next_ap[bank] = 1'b1;
                  next_busy     = DAL_CYC;
               end
            end
            SCL_CMD_PRECHARGE: begin
               if (i_addr[`SCL_AP_BIT]) begin
                  next_open = 2'h0;
               end else begin
                  next_open[bank] = 1'b0;
               end
               next_busy = RP_CYC;
            end
            SCL_CMD_REFRESH:  next_busy = RP_CYC;
            SCL_CMD_MODE_SET: next_busy = MCD_CYC;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         open       <= 2'h0;
         ap         <= 2'h0;
         busy       <= 8'h00;
         rrd        <= 8'h00;
         rcd        <= '{8'h00, 8'h00};
         ras        <= '{8'h00, 8'h00};
         link.cke   <= 1'b1;
         link.cs_n  <= 1'b1;
         link.ras_n <= 1'b1;
         link.cas_n <= 1'b1;
         link.we_n  <= 1'b1;
         link.addr  <= 12'h000;
      end else begin
         open       <= next_open;
         ap         <= next_ap;
         busy       <= next_busy;
         rrd        <= next_rrd;
         rcd        <= next_rcd;
         ras        <= next_ras;
         link.cke   <= i_cke;
         {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= pins;
         link.addr  <= i_addr;
      end
   end
endmodule : scl_controller

// ===== test/scl_link_chk.sv
module scl_link_chk
   import scl_pkg::*;
(
   input  wire logic        i_core_clk,      // clock
   input  wire logic        i_reset_n,       // async reset
   input  wire logic        cke,             // clock enable pin
   input  wire logic        cs_n,            // chip select, low active
   input  wire logic        ras_n,           // row strobe, low active
   input  wire logic        cas_n,           // column strobe, low active
   input  wire logic        we_n,            // write enable, low active
   input  wire logic [11:0] addr,            // address pins
   input  scl_state_t       o_state,         // device state
   input  wire logic [11:0] o_mode,          // mode register
   input  wire logic [1:0]  o_bank_open,     // bank active flags
   input  wire logic        o_clk_suspended, // internal clock held
   input  wire logic        o_illegal        // illegal command pulse
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   logic [3:0] code;
   assign code = {cs_n, ras_n, cas_n, we_n};

   // ==========================================================
   // command effects
   property p_mode_load;
      (cke && code == 4'h0 && o_state == SCL_ST_IDLE)
         |=> o_mode == $past(addr);
   endproperty
   a_mode_load: assert property (p_mode_load)
      else $error("mode register not loaded from address");
   property p_mode_wait;
      $rose(o_state == SCL_ST_MODE_SET) |-> ##[1:3] o_state == SCL_ST_IDLE;
   endproperty
   a_mode_wait: assert property (p_mode_wait)
      else $error("mode set wait not ended");
   property p_ref_idle;
      $rose(o_state == SCL_ST_REFRESH) |-> ##[1:3] o_state == SCL_ST_IDLE;
   endproperty
   a_ref_idle: assert property (p_ref_idle)
      else $error("refresh not back to idle");
   property p_wap_idle;
      $rose(o_state == SCL_ST_WRITE_AP) |-> ##[1:12] o_state == SCL_ST_IDLE;
   endproperty
   a_wap_idle: assert property (p_wap_idle)
      else $error("write recovery not back to idle");
   property p_act_open;
      (cke && code == 4'h3) |=> o_bank_open[$past(addr[11])];
   endproperty
   a_act_open: assert property (p_act_open)
      else $error("activate did not open bank");
   // the controller never issues an illegal command, so no flag
   property p_no_illegal;
      !o_illegal;
   endproperty
   a_no_illegal: assert property (p_no_illegal)
      else $error("illegal flag on legal traffic");

   // ==========================================================
   // clock enable
   property p_self_entry;
      ($past(cke) && !cke && code == 4'h1 && o_state == SCL_ST_IDLE)
         |=> o_state == SCL_ST_SELF_REFRESH;
   endproperty
   a_self_entry: assert property (p_self_entry)
      else $error("self refresh not entered");
   property p_self_hold;
      (o_state == SCL_ST_SELF_REFRESH && !cke)
         |=> o_state == SCL_ST_SELF_REFRESH;
   endproperty
   a_self_hold: assert property (p_self_hold)
      else $error("self refresh left with enable low");
   property p_recover;
      $rose(o_state == SCL_ST_SELF_RECOVERY)
         |-> ##[1:9] o_state == SCL_ST_IDLE;
   endproperty
   a_recover: assert property (p_recover)
      else $error("self refresh recovery not ended");
   property p_pd_exit;
      (o_state == SCL_ST_POWER_DOWN && cke) |-> ##[1:2] o_state == SCL_ST_IDLE;
   endproperty
   a_pd_exit: assert property (p_pd_exit)
      else $error("power down not ended");
   property p_suspend;
      ($fell(cke) && o_state == SCL_ST_ACTIVE) |-> ##[1:2] o_clk_suspended;
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("clock suspend not started");
   property p_resume;
      (o_clk_suspended && cke) |-> ##[1:2] !o_clk_suspended;
   endproperty
   a_resume: assert property (p_resume)
      else $error("clock suspend not ended");

   c_self: cover property (o_state == SCL_ST_SELF_REFRESH);
   c_pd: cover property (o_state == SCL_ST_POWER_DOWN);
   c_susp: cover property (o_clk_suspended);
endmodule : scl_link_chk

// ===== test/sdram_command_state_logic_test.sv
module sdram_command_state_logic_test
   import scl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              i_core_clk = 1'b0;
   logic              i_reset_n;
   logic              req;
   scl_cmd_t          cmd;
   logic [11:0]       addr;
   logic              cke;
   logic              ready;
   scl_state_t        state;
   logic [11:0]       mode;
   logic [1:0]        bank_open;
   logic              suspended;
   logic              illegal;
   logic [11:0]       row;
   int                num_errors = 0;
   int                checks = 0;

   scl_link_if link();
   scl_controller u_scl_controller (.i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n), .i_req(req), .i_cmd(cmd), .i_addr(addr),
      .i_cke(cke), .o_ready(ready), .link(link));
   scl_device u_scl_device (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .link(link), .o_mode(mode), .o_state(state), .o_bank_open(bank_open),
      .o_clk_suspended(suspended), .o_illegal(illegal), .o_refresh_row(row));
   scl_link_chk u_scl_link_chk (.i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n), .cke(link.cke), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
      .addr(link.addr), .o_state(state), .o_mode(mode),
      .o_bank_open(bank_open), .o_clk_suspended(suspended),
      .o_illegal(illegal));

   always #5 i_core_clk = ~i_core_clk;

   // ==========================================================
   // shared tasks
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_core_clk);
         #1;
      end
   endtask : tick

   // ready is combinational, so it is judged at the falling edge
   task automatic issue(input scl_cmd_t c, input logic [11:0] a);
      int n;
      n = 0;
      req = 1'b1;
      cmd = c;
      addr = a;
      do begin
         @(negedge i_core_clk);
         n++;
      end while (ready !== 1'b1 && n < 40);
      tick(1);
      req = 1'b0;
      chk(n < 40, "request not taken");
   endtask : issue

   task automatic wait_st(input scl_state_t s, input int lim,
                          input string msg);
      int n;
      n = 0;
      while (state !== s && n < lim) begin
         tick(1);
         n++;
      end
      chk(state === s, msg);
   endtask : wait_st

   // ==========================================================
   // scenarios
   task automatic t_mode;
      issue(SCL_CMD_MODE_SET, 12'h023);
      wait_st(SCL_ST_MODE_SET, 3, "mode set state missing");
      wait_st(SCL_ST_IDLE, 4, "mode set wait too long");
      chk(mode === 12'h023, "mode register wrong");
   endtask : t_mode

   task automatic t_refresh;
      logic [11:0] r;
      r = row;
      issue(SCL_CMD_REFRESH, 12'hFFF);
      wait_st(SCL_ST_REFRESH, 3, "refresh state missing");
      wait_st(SCL_ST_IDLE, 4, "refresh wait too long");
      chk(row === r + 12'h001, "refresh row not stepped");
   endtask : t_refresh

   task automatic t_wap;
      issue(SCL_CMD_ACTIVATE, 12'h005);
      wait_st(SCL_ST_ACTIVE, 3, "bank not active");
      chk(bank_open === 2'h1, "bank 0 not open");
      issue(SCL_CMD_WRITE, 12'h400);
      wait_st(SCL_ST_WRITE_AP, 4, "write recovery missing");
      wait_st(SCL_ST_IDLE, 12, "write recovery too long");
      chk(bank_open === 2'h0, "bank not closed");
   endtask : t_wap

   task automatic t_suspend;
      issue(SCL_CMD_ACTIVATE, 12'h805);
      wait_st(SCL_ST_ACTIVE, 3, "bank 1 not active");
      cke = 1'b0;
      tick(4);
      chk(suspended === 1'b1, "clock not suspended");
      cke = 1'b1;
      tick(3);
      chk(suspended === 1'b0, "suspend not ended");
      issue(SCL_CMD_PRECHARGE, 12'h400);
      wait_st(SCL_ST_IDLE, 6, "precharge all failed");
      chk(bank_open === 2'h0, "banks still open");
   endtask : t_suspend

   task automatic t_pdown;
      cke = 1'b0;
      wait_st(SCL_ST_POWER_DOWN, 4, "power down missing");
      cke = 1'b1;
      wait_st(SCL_ST_IDLE, 3, "power down not left");
   endtask : t_pdown

   task automatic t_selfref;
      // let the power-down recovery wait run out, so that the enable
      // falls together with the refresh code and not on its own
      tick(8);
      cke = 1'b0;
      issue(SCL_CMD_REFRESH, 12'h000);
      wait_st(SCL_ST_SELF_REFRESH, 4, "self refresh missing");
      tick(8);
      chk(state === SCL_ST_SELF_REFRESH, "self refresh left");
      cke = 1'b1;
      wait_st(SCL_ST_SELF_RECOVERY, 3, "recovery missing");
      wait_st(SCL_ST_IDLE, 10, "recovery too long");
   endtask : t_selfref

   task automatic final_report;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   initial begin
      i_reset_n = 1'b0;
      req = 1'b0;
      cmd = SCL_CMD_NOP;
      addr = 12'h000;
      cke = 1'b1;
      repeat (4) @(posedge i_core_clk);
      #1;
      i_reset_n = 1'b1;
      t_mode();
      t_refresh();
      t_wap();
      t_suspend();
      t_pdown();
      t_selfref();
      final_report();
   end

   // the scenarios need well under a thousand cycles
   initial begin
      #100000;
      num_errors++;
      final_report();
   end
endmodule : sdram_command_state_logic_test
